// file: istd_pkg.sv
// Constants for the input source type detection sequencer.
// Assumes a 25 MHz core clock; all limits are 50 mA codes above a 100 mA base.
package istd_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned DCD_TIMEOUT_MS = 500;
   localparam int unsigned DCD_CYCLES = DCD_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned BC_SETTLE_US = 40;
   localparam int unsigned BC_SETTLE_CYCLES = BC_SETTLE_US * (CLK_HZ / 1000000);
   localparam int unsigned HV_HOLD_MS = 2;
   localparam int unsigned HV_HOLD_CYCLES = HV_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned INT_PULSE_CYCLES = 6;
   // Current limit codes: mA = 100 + 50 * code
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_SDP = 6'h08;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_CDP = 6'h1c;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_DCP = 6'h3e;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_DIV1 = 6'h28;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_DIV2 = 6'h26;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_DIV3 = 6'h12;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_DIV4 = 6'h2e;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_UNKNOWN = 6'h08;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_RESET = 6'h08;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_PSEL_LO = 6'h3e;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_PSEL_HI_OTG = 6'h08;
   localparam logic [5:0] EXT_CURRENT_LIMIT_PIN_PSEL_HI = 6'h00;
   // Source type field encodings
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_SDP = 3'h1;
   localparam logic [2:0] SRC_CDP = 3'h2;
   localparam logic [2:0] SRC_DCP = 3'h3;
   localparam logic [2:0] SRC_HV = 3'h4;
   localparam logic [2:0] SRC_UNKNOWN = 3'h5;
   localparam logic [2:0] SRC_NONSTD = 3'h6;
   // Line drive select bits: [0] D+ source, [1] D+ sink, [2] D- source, [3] D- sink
   localparam logic [3:0] DRV_OFF = 4'h0;
   localparam logic [3:0] DRV_HV12 = 4'h6;
   localparam logic [3:0] DRV_HV9 = 4'h9;
   localparam logic [3:0] DRV_BC = 4'h1;
endpackage : istd_pkg

// file: istd_pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module istd_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
   logic [WIDTH-1:0] out_nxt;

   always_comb begin
      out_nxt = out_r;
      // Only the agreeing later stages decide; the first stage stays private
      for (int k = 0; k < WIDTH; k++) begin
         if (s2_r[k] == s3_r[k]) begin
            out_nxt[k] = s2_r[k];
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         out_r <= '0;
      end else begin
         s1_r <= i_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign o_sync = out_r;
endmodule : istd_pin_sync
`default_nettype wire

// file: istd_detect.sv
// Input source type detection sequencer: BC1.2, non-standard dividers,
// high-voltage handshake, or strapped select pins on the strapped variant.
// Assumes analog comparators on D+/D- and a host that writes override limits.
//
// Contract
// - Detection starts only once input good is set, the regulator is up and auto detect is on.
// - On attach, standard BC1.2 detection classifies SDP, CDP or DCP first.
// - If the 500 ms data contact timer expires, non-standard adapter detection sets the limit.
// - Divider patterns one to four give 2.1 A, 2 A, 1 A and 2.4 A.
// - A detected DCP starts a handshake asking the adapter to rise from 5 V to 9 V or 12 V.
// - The handshake runs only while at least one handshake enable bit is set.
// - 12 V sinks on D+ and sources on D-, 9 V the reverse; the adapter answers in kind.
// - On completion an interrupt pulse, the new limit and power good status are produced.
// - On the strapped variant the active-low power good pin goes low at completion.
// - The host may overwrite the limit after detection and the written value applies.
// - The applied limit is always the lower of the register limit and the external pin.
// - With auto detect off, detection is skipped and limit, type and USB flag hold.
// - The strapped variant takes its limit from the select and OTG pins.
// - On the detecting variant, completion updates source type and USB flag together with the limit; the strapped variant sets only the limit.
// - Input good and its interrupt come only after the overvoltage and load checks pass.
`timescale 1ns/1ps
`default_nettype none
module istd_detect #(
   parameter bit STRAPPED = 1'b0,
   parameter int unsigned DCD_CYCLES = istd_pkg::DCD_CYCLES,
   parameter int unsigned HV_HOLD_CYCLES = istd_pkg::HV_HOLD_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_source_ovp_ok,
   input wire logic i_source_load_ok,
   input wire logic i_regulator_ok,
   input wire logic i_auto_detect_enable,
   input wire logic i_hv_handshake_a_enable,
   input wire logic i_hv_handshake_b_enable,
   input wire logic i_hv_request_12v,
   input wire logic i_dp_contact,
   input wire logic i_dp_data_high,
   input wire logic i_dm_data_high,
   input wire logic [3:0] i_dp_window,
   input wire logic [3:0] i_dm_window,
   input wire logic i_source_select,
   input wire logic i_otg_pin,
   input wire logic i_host_limit_write,
   input wire logic [5:0] i_host_limit_data,
   input wire logic [5:0] i_ext_current_limit_pin,
   output logic o_input_good_flag,
   output logic [5:0] o_input_current_limit,
   output logic [5:0] o_applied_current_limit,
   output logic [2:0] o_source_type_field,
   output logic o_usb_input_flag,
   output logic o_power_good_flag,
   output logic o_power_good_pin_n,
   output logic [3:0] o_line_drive,
   output logic o_detect_busy,
   output logic o_int_pulse
);
   // The shared step timer is 25 bits wide, so longer counts cannot be served
   if (DCD_CYCLES < 2 || HV_HOLD_CYCLES < 2 || DCD_CYCLES > 2**25 ||
      HV_HOLD_CYCLES > 2**25) begin : g_bad_param
      $error("istd_detect: timer counts must lie between 2 and 2**25");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DCD = 3'b001,
      ST_PRIMARY = 3'b010,
      ST_SECONDARY = 3'b011,
      ST_NONSTD = 3'b100,
      ST_HV = 3'b101,
      ST_DONE = 3'b110
   } istd_state_type;

   // Comparator and strap levels come from the analog side, asynchronous to us
   logic [12:0] pins_raw, pins_s;
   assign pins_raw = {i_dp_contact, i_dp_data_high, i_dm_data_high, i_dp_window,
      i_dm_window, i_source_select, i_otg_pin};

   istd_pin_sync #(.WIDTH(13)) u_sync (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_async(pins_raw),
      .o_sync(pins_s)
   );

   logic dp_contact, dp_high, dm_high, psel, otg;
   logic [3:0] dp_win, dm_win;
   assign dp_contact = pins_s[12];
   assign dp_high = pins_s[11];
   assign dm_high = pins_s[10];
   assign dp_win = pins_s[9:6];
   assign dm_win = pins_s[5:2];
   assign psel = pins_s[1];
   assign otg = pins_s[0];
   // Window bits: [0] 1.2 V, [1] 2.0 V, [2] 2.7 V, [3] spare

   istd_state_type state_r, state_nxt;
   logic [24:0] tmr_r, tmr_nxt;
   logic good_r, good_nxt;
   logic [5:0] lim_r, lim_nxt;
   logic [2:0] type_r, type_nxt;
   logic usb_r, usb_nxt;
   logic pg_r, pg_nxt;
   logic [3:0] drv_r, drv_nxt;
   logic [2:0] irq_r, irq_nxt;
   logic hv_en, start;

   assign hv_en = i_hv_handshake_a_enable | i_hv_handshake_b_enable;
   assign start = good_r && i_regulator_ok && i_auto_detect_enable;

   always_comb begin
      state_nxt = state_r;
      tmr_nxt = tmr_r;
      good_nxt = i_source_ovp_ok && i_source_load_ok;
      lim_nxt = lim_r;
      type_nxt = type_r;
      usb_nxt = usb_r;
      pg_nxt = pg_r;
      drv_nxt = drv_r;
      irq_nxt = (irq_r != 3'h0) ? irq_r - 3'h1 : 3'h0;
      // Rising input good pulses the interrupt
      if (good_nxt && !good_r) begin
         irq_nxt = 3'(istd_pkg::INT_PULSE_CYCLES);
      end
      if (!good_nxt) begin
         pg_nxt = 1'b0;
      end
      // A host write wins over everything except a completing detection
      if (i_host_limit_write) begin
         lim_nxt = i_host_limit_data;
      end
      case (state_r)
         ST_IDLE: begin
            drv_nxt = istd_pkg::DRV_OFF;
            if (start && !pg_r) begin
               tmr_nxt = '0;
               state_nxt = STRAPPED ? ST_DONE : ST_DCD;
               if (STRAPPED) begin
                  lim_nxt = !psel ? istd_pkg::EXT_CURRENT_LIMIT_PIN_PSEL_LO
                     : (otg ? istd_pkg::EXT_CURRENT_LIMIT_PIN_PSEL_HI_OTG : istd_pkg::EXT_CURRENT_LIMIT_PIN_PSEL_HI);
                  pg_nxt = 1'b1;
                  irq_nxt = 3'(istd_pkg::INT_PULSE_CYCLES);
               end
            end
         end
         ST_DCD: begin
            tmr_nxt = tmr_r + 25'h1;
            drv_nxt = istd_pkg::DRV_BC;
            if (dp_contact) begin
               tmr_nxt = '0;
               state_nxt = ST_PRIMARY;
            end else if (tmr_r >= 25'(DCD_CYCLES - 1)) begin
               state_nxt = ST_NONSTD;
            end
         end
         ST_PRIMARY: begin
            tmr_nxt = tmr_r + 25'h1;
            if (tmr_r >= 25'(istd_pkg::BC_SETTLE_CYCLES - 1)) begin
               tmr_nxt = '0;
               if (!dm_high) begin
                  type_nxt = istd_pkg::SRC_SDP;
                  usb_nxt = 1'b1;
                  lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_SDP;
                  state_nxt = ST_DONE;
               end else begin
                  state_nxt = ST_SECONDARY;
               end
            end
         end
         ST_SECONDARY: begin
            tmr_nxt = tmr_r + 25'h1;
            if (tmr_r >= 25'(istd_pkg::BC_SETTLE_CYCLES - 1)) begin
               tmr_nxt = '0;
               usb_nxt = 1'b1;
               if (dp_high) begin
                  type_nxt = istd_pkg::SRC_DCP;
                  lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_DCP;
                  state_nxt = hv_en ? ST_HV : ST_DONE;
               end else begin
                  type_nxt = istd_pkg::SRC_CDP;
                  lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_CDP;
                  state_nxt = ST_DONE;
               end
            end
         end
         ST_NONSTD: begin
            usb_nxt = 1'b0;
            type_nxt = istd_pkg::SRC_NONSTD;
            if (dp_win[2] && dm_win[1]) begin
               lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV1;
            end else if (dp_win[0] && dm_win[0]) begin
               lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV2;
            end else if (dp_win[1] && dm_win[2]) begin
               lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV3;
            end else if (dp_win[2] && dm_win[2]) begin
               lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV4;
            end else begin
               type_nxt = istd_pkg::SRC_UNKNOWN;
               lim_nxt = istd_pkg::EXT_CURRENT_LIMIT_PIN_UNKNOWN;
            end
            state_nxt = ST_DONE;
         end
         ST_HV: begin
            tmr_nxt = tmr_r + 25'h1;
            drv_nxt = i_hv_request_12v ? istd_pkg::DRV_HV12 : istd_pkg::DRV_HV9;
            // Clearing both enables abandons the request but keeps the DCP result
            if (!hv_en) begin
               drv_nxt = istd_pkg::DRV_OFF;
               state_nxt = ST_DONE;
            end else if (tmr_r >= 25'(HV_HOLD_CYCLES - 1)) begin
               type_nxt = istd_pkg::SRC_HV;
               state_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            if (!STRAPPED) begin
               drv_nxt = (type_r == istd_pkg::SRC_HV) ? drv_r : istd_pkg::DRV_OFF;
               pg_nxt = 1'b1;
               if (!pg_r) begin
                  irq_nxt = 3'(istd_pkg::INT_PULSE_CYCLES);
               end
            end
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Removal of the source aborts any detection and clears power good; limit, type and USB flag hold
      if (!good_nxt) begin
         state_nxt = ST_IDLE;
         drv_nxt = istd_pkg::DRV_OFF;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         state_r <= ST_IDLE;
         tmr_r <= '0;
         good_r <= 1'b0;
         lim_r <= istd_pkg::EXT_CURRENT_LIMIT_PIN_RESET;
         type_r <= istd_pkg::SRC_NONE;
         usb_r <= 1'b0;
         pg_r <= 1'b0;
         drv_r <= istd_pkg::DRV_OFF;
         irq_r <= 3'h0;
      end else begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         good_r <= good_nxt;
         lim_r <= lim_nxt;
         type_r <= type_nxt;
         usb_r <= usb_nxt;
         pg_r <= pg_nxt;
         drv_r <= drv_nxt;
         irq_r <= irq_nxt;
      end
   end

   logic [5:0] applied_r;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         applied_r <= istd_pkg::EXT_CURRENT_LIMIT_PIN_RESET;
      end else begin
         applied_r <= (lim_r < i_ext_current_limit_pin) ? lim_r : i_ext_current_limit_pin;
      end
   end

   assign o_input_good_flag = good_r;
   assign o_input_current_limit = lim_r;
   assign o_applied_current_limit = applied_r;
   assign o_source_type_field = type_r;
   assign o_usb_input_flag = usb_r;
   assign o_power_good_flag = pg_r;
   assign o_power_good_pin_n = ~(pg_r & STRAPPED);
   assign o_line_drive = drv_r;
   assign o_detect_busy = (state_r != ST_IDLE);
   assign o_int_pulse = (irq_r != 3'h0);
endmodule : istd_detect
`default_nettype wire

// file: istd_detect_monitor.sv
// Concurrent checks on the ports of the source type detection sequencer.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module istd_detect_monitor #(
   parameter bit STRAPPED = 1'b0,
   parameter int unsigned DCD_CYCLES = 1,
   parameter int unsigned HV_HOLD_CYCLES = 1
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_source_ovp_ok,
   input wire logic i_source_load_ok,
   input wire logic i_regulator_ok,
   input wire logic i_auto_detect_enable,
   input wire logic i_hv_handshake_a_enable,
   input wire logic i_hv_handshake_b_enable,
   input wire logic i_hv_request_12v,
   input wire logic [5:0] i_ext_current_limit_pin,
   input wire logic o_input_good_flag,
   input wire logic [5:0] o_input_current_limit,
   input wire logic [5:0] o_applied_current_limit,
   input wire logic [2:0] o_source_type_field,
   input wire logic o_usb_input_flag,
   input wire logic o_power_good_flag,
   input wire logic o_power_good_pin_n,
   input wire logic [3:0] o_line_drive,
   input wire logic o_detect_busy,
   input wire logic o_int_pulse
);
   default clocking dc @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   logic [25:0] busy_cnt_r;
   always_ff @(posedge i_clock) begin
      if (!i_reset_n || !o_detect_busy) begin
         busy_cnt_r <= '0;
      end else begin
         busy_cnt_r <= busy_cnt_r + 26'h1;
      end
   end

   // Longest legal run: full contact wait, both settles, the handshake and the done step
   chk_busy_bound: assert property (busy_cnt_r <= 26'(DCD_CYCLES +
      2 * istd_pkg::BC_SETTLE_CYCLES + HV_HOLD_CYCLES + 4))
      else $error("detection ran past its timers");
   chk_applied_min: assert property ($past(i_reset_n) |-> o_applied_current_limit ==
      (($past(o_input_current_limit) < $past(i_ext_current_limit_pin)) ?
      $past(o_input_current_limit) : $past(i_ext_current_limit_pin)))
      else $error("applied limit is not the lower limit");
   chk_int_width: assert property ($rose(o_int_pulse) |-> o_int_pulse [*6])
      else $error("interrupt pulse too short");
   chk_done_int: assert property ($rose(o_power_good_flag) |-> o_int_pulse)
      else $error("power good without interrupt");
   chk_pair_update: assert property (!STRAPPED && $changed(o_usb_input_flag)
      |-> $changed(o_source_type_field))
      else $error("usb flag moved without source type");
   chk_start_cond: assert property ($rose(o_detect_busy)
      |-> $past(o_input_good_flag && i_regulator_ok && i_auto_detect_enable))
      else $error("detection started without its conditions");
   chk_auto_off: assert property (!STRAPPED && !i_auto_detect_enable && !o_detect_busy
      |=> !o_detect_busy)
      else $error("detection started with auto detect off");
   chk_hv_enable: assert property ($changed(o_line_drive) &&
      (o_line_drive == istd_pkg::DRV_HV12 || o_line_drive == istd_pkg::DRV_HV9)
      |-> $past(i_hv_handshake_a_enable || i_hv_handshake_b_enable))
      else $error("handshake drive with both enables clear");
   chk_hv_twelve: assert property ($changed(o_line_drive) &&
      o_line_drive == istd_pkg::DRV_HV12 |-> $past(i_hv_request_12v))
      else $error("12 V drive without 12 V request");
   chk_hv_nine: assert property ($changed(o_line_drive) &&
      o_line_drive == istd_pkg::DRV_HV9 |-> !$past(i_hv_request_12v))
      else $error("9 V drive with 12 V request");
   chk_pin_idle: assert property (!STRAPPED |-> o_power_good_pin_n)
      else $error("power good pin low on the detecting variant");
   chk_good_cause: assert property ($rose(o_input_good_flag)
      |-> $past(i_source_ovp_ok && i_source_load_ok))
      else $error("input good without source checks");
endmodule : istd_detect_monitor

bind istd_detect istd_detect_monitor #(
   .STRAPPED(STRAPPED), .DCD_CYCLES(DCD_CYCLES), .HV_HOLD_CYCLES(HV_HOLD_CYCLES)
) istd_detect_monitor_inst (
   .i_clock(i_clock), .i_reset_n(i_reset_n), .i_source_ovp_ok(i_source_ovp_ok),
   .i_source_load_ok(i_source_load_ok), .i_regulator_ok(i_regulator_ok),
   .i_auto_detect_enable(i_auto_detect_enable),
   .i_hv_handshake_a_enable(i_hv_handshake_a_enable),
   .i_hv_handshake_b_enable(i_hv_handshake_b_enable), .i_hv_request_12v(i_hv_request_12v),
   .i_ext_current_limit_pin(i_ext_current_limit_pin), .o_input_good_flag(o_input_good_flag),
   .o_input_current_limit(o_input_current_limit),
   .o_applied_current_limit(o_applied_current_limit),
   .o_source_type_field(o_source_type_field), .o_usb_input_flag(o_usb_input_flag),
   .o_power_good_flag(o_power_good_flag), .o_power_good_pin_n(o_power_good_pin_n),
   .o_line_drive(o_line_drive), .o_detect_busy(o_detect_busy), .o_int_pulse(o_int_pulse)
);
`default_nettype wire

// file: istd_port_model.sv
// Behavioural USB port or adapter seen through the D+/D- comparators.
// Assumes the detector's line drive code; kind is chosen by the bench.
`timescale 1ns/1ps
`default_nettype none
module istd_port_model (
   input wire logic [2:0] i_kind,
   input wire logic [3:0] i_line_drive,
   output logic o_dp_contact,
   output logic o_dp_data_high,
   output logic o_dm_data_high,
   output logic [7:0] o_windows
);
   // Kind: 0 nothing, 1 SDP, 2 CDP, 3 DCP, 4 to 7 divider one to four
   logic bc;
   assign bc = (i_line_drive === istd_pkg::DRV_BC);
   // Dividers never make data contact, so only the timer ends their wait
   assign o_dp_contact = (i_kind inside {3'h1, 3'h2, 3'h3});
   // Undriven lines sit at the pull-down level
   assign o_dm_data_high = bc && (i_kind inside {3'h2, 3'h3});
   assign o_dp_data_high = bc && (i_kind == 3'h3);
   assign o_windows = (i_kind == 3'h4) ? 8'h42 : (i_kind == 3'h5) ? 8'h11 :
      (i_kind == 3'h6) ? 8'h24 : (i_kind == 3'h7) ? 8'h44 : 8'h00;
endmodule : istd_port_model
`default_nettype wire

// file: istd_detect_bench.sv
// Self-checking bench: detecting and strapped variants side by side.
// Assumes short timer parameters; the port model answers on D+/D-.
`timescale 1ns/1ps
`default_nettype none
module istd_detect_bench;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic src_ok = 1'b0, reg_ok = 1'b0, auto_en = 1'b1, hva = 1'b0, hvb = 1'b0;
   logic req12 = 1'b0, psel = 1'b0, otg = 1'b0, hwr = 1'b0;
   logic [5:0] hdata = 6'h00, ext = 6'h3f, lim, app, lim_s;
   logic [2:0] kind = 3'h0, typ;
   logic [3:0] drive;
   logic [7:0] win;
   logic contact, dph, dmh, usb, pg, pgn_s;
   int mismatches = 0, compares = 0;

   initial forever #20 i_clock = ~i_clock;

   istd_port_model istd_port_model_inst (.i_kind(kind), .i_line_drive(drive),
      .o_dp_contact(contact), .o_dp_data_high(dph), .o_dm_data_high(dmh), .o_windows(win));
   istd_detect #(.STRAPPED(1'b0), .DCD_CYCLES(200), .HV_HOLD_CYCLES(50)) istd_detect_inst (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_source_ovp_ok(src_ok),
      .i_source_load_ok(src_ok), .i_regulator_ok(reg_ok), .i_auto_detect_enable(auto_en),
      .i_hv_handshake_a_enable(hva), .i_hv_handshake_b_enable(hvb), .i_hv_request_12v(req12),
      .i_dp_contact(contact), .i_dp_data_high(dph), .i_dm_data_high(dmh),
      .i_dp_window(win[7:4]), .i_dm_window(win[3:0]), .i_source_select(psel),
      .i_otg_pin(otg), .i_host_limit_write(hwr), .i_host_limit_data(hdata),
      .i_ext_current_limit_pin(ext), .o_input_good_flag(), .o_input_current_limit(lim),
      .o_applied_current_limit(app), .o_source_type_field(typ), .o_usb_input_flag(usb),
      .o_power_good_flag(pg), .o_power_good_pin_n(), .o_line_drive(drive),
      .o_detect_busy(), .o_int_pulse());
   istd_detect #(.STRAPPED(1'b1), .DCD_CYCLES(200), .HV_HOLD_CYCLES(50)) istd_detect_strap_inst (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_source_ovp_ok(src_ok),
      .i_source_load_ok(src_ok), .i_regulator_ok(reg_ok), .i_auto_detect_enable(auto_en),
      .i_hv_handshake_a_enable(hva), .i_hv_handshake_b_enable(hvb), .i_hv_request_12v(req12),
      .i_dp_contact(contact), .i_dp_data_high(dph), .i_dm_data_high(dmh),
      .i_dp_window(win[7:4]), .i_dm_window(win[3:0]), .i_source_select(psel),
      .i_otg_pin(otg), .i_host_limit_write(hwr), .i_host_limit_data(hdata),
      .i_ext_current_limit_pin(ext), .o_input_good_flag(), .o_input_current_limit(lim_s),
      .o_applied_current_limit(), .o_source_type_field(), .o_usb_input_flag(),
      .o_power_good_flag(), .o_power_good_pin_n(pgn_s), .o_line_drive(),
      .o_detect_busy(), .o_int_pulse());

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Sel 0 waits for power good, 1 for the 12 V drive, 2 for the 9 V drive
   task automatic wait_until(input int sel);
      int n;
      for (n = 0; n < 6000; n++) begin
         @(negedge i_clock);
         if ((sel == 0 && pg === 1'b1) || (sel == 1 && drive === istd_pkg::DRV_HV12) ||
             (sel == 2 && drive === istd_pkg::DRV_HV9))
            break;
      end
      if (n == 6000) begin
         mismatches++;
         $display("CHECK FAILED at %0t: wait ran out", $time);
         end_sim();
      end else begin
         repeat (2) @(negedge i_clock);
      end
   endtask : wait_until

   task automatic plug(input logic [2:0] k, input logic up);
      @(posedge i_clock);
      kind <= k;
      src_ok <= up;
      reg_ok <= 1'b1;
      repeat (10) @(posedge i_clock);
   endtask : plug

   task automatic t_bc;
      logic [8:0] exp [1:3];
      exp[1] = {istd_pkg::EXT_CURRENT_LIMIT_PIN_SDP, istd_pkg::SRC_SDP};
      exp[2] = {istd_pkg::EXT_CURRENT_LIMIT_PIN_CDP, istd_pkg::SRC_CDP};
      exp[3] = {istd_pkg::EXT_CURRENT_LIMIT_PIN_DCP, istd_pkg::SRC_DCP};
      for (int k = 1; k <= 3; k++) begin
         plug(3'(k), 1'b1);
         wait_until(0);
         chk({lim, typ}, exp[k]);
         chk({app, 3'h0}, {exp[k][8:3], 3'h0});
         if (k < 3)
            chk({8'h00, usb}, 9'h001);
         plug(3'h0, 1'b0);
      end
      $display("standard detection test done");
   endtask : t_bc

   task automatic t_hv;
      for (int i = 0; i < 2; i++) begin
         @(posedge i_clock);
         hva <= (i == 0);
         hvb <= (i == 1);
         req12 <= (i == 0);
         plug(3'h3, 1'b1);
         wait_until(i + 1);
         wait_until(0);
         chk({6'h00, typ}, {6'h00, istd_pkg::SRC_HV});
         plug(3'h0, 1'b0);
      end
      hva <= 1'b0;
      hvb <= 1'b0;
      $display("handshake test done");
   endtask : t_hv

   task automatic t_div;
      logic [5:0] exp [4:7];
      exp[4] = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV1;
      exp[5] = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV2;
      exp[6] = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV3;
      exp[7] = istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV4;
      for (int k = 4; k <= 7; k++) begin
         plug(3'(k), 1'b1);
         wait_until(0);
         chk({lim, typ}, {exp[k], istd_pkg::SRC_NONSTD});
         plug(3'h0, 1'b0);
      end
      $display("divider test done");
   endtask : t_div

   task automatic t_auto_host;
      @(posedge i_clock);
      auto_en <= 1'b0;
      plug(3'h1, 1'b1);
      repeat (3000) @(negedge i_clock);
      chk({lim, typ}, {istd_pkg::EXT_CURRENT_LIMIT_PIN_DIV4, istd_pkg::SRC_NONSTD});
      chk({8'h00, pg}, 9'h000);
      @(posedge i_clock);
      reg_ok <= 1'b0;
      auto_en <= 1'b1;
      repeat (20) @(negedge i_clock);
      chk({8'h00, pg}, 9'h000);
      @(posedge i_clock);
      reg_ok <= 1'b1;
      wait_until(0);
      chk({lim, typ}, {istd_pkg::EXT_CURRENT_LIMIT_PIN_SDP, istd_pkg::SRC_SDP});
      @(posedge i_clock);
      hwr <= 1'b1;
      hdata <= 6'h15;
      @(posedge i_clock);
      hwr <= 1'b0;
      repeat (2) @(negedge i_clock);
      chk({lim, app[2:0]}, {6'h15, 3'h5});
      @(posedge i_clock);
      ext <= 6'h0a;
      repeat (2) @(negedge i_clock);
      chk({3'h0, app}, 9'h00a);
      @(posedge i_clock);
      ext <= 6'h3f;
      plug(3'h0, 1'b0);
      $display("auto off and host write test done");
   endtask : t_auto_host

   task automatic t_strap;
      logic [5:0] exp [3];
      exp[0] = istd_pkg::EXT_CURRENT_LIMIT_PIN_PSEL_LO;
      exp[1] = istd_pkg::EXT_CURRENT_LIMIT_PIN_PSEL_HI_OTG;
      exp[2] = istd_pkg::EXT_CURRENT_LIMIT_PIN_PSEL_HI;
      for (int i = 0; i < 3; i++) begin
         @(posedge i_clock);
         psel <= (i != 0);
         otg <= (i == 1);
         plug(3'h0, 1'b0);
         chk({8'h00, pgn_s}, 9'h001);
         plug(3'h0, 1'b1);
         wait_until(0);
         chk({pgn_s, 2'h0, lim_s}, {1'b0, 2'h0, exp[i]});
         chk({lim, typ}, {istd_pkg::EXT_CURRENT_LIMIT_PIN_UNKNOWN, istd_pkg::SRC_UNKNOWN});
      end
      $display("strapped variant test done");
   endtask : t_strap

   initial begin
      repeat (5) @(posedge i_clock);
      i_reset_n <= 1'b1;
      t_bc();
      t_hv();
      t_div();
      t_auto_host();
      t_strap();
      end_sim();
   end
endmodule : istd_detect_bench
`default_nettype wire
